// File: sync_clock_params.svh
// Register offsets, field positions, reset values and timing constants for the sync and digital clock block.
`ifndef SYNC_CLOCK_PARAMS_SVH
`define SYNC_CLOCK_PARAMS_SVH
`define REG_STD_SEL 8'h38
`define REG_FREQ_SEL 8'h39
`define REG_SYNC_EN 8'h63
`define REG_SYNC_FORM 8'h7A
`define RST_STD_SEL 8'h00
`define RST_FREQ_SEL 8'h00
`define RST_SYNC_EN 8'h00
`define RST_SYNC_FORM 8'h00
`define BIT_STD_A 5
`define BIT_STD_B 6
`define FLD_FREQ_A_LSB 4
`define FLD_FREQ_B_LSB 6
`define BIT_FRAME_DIS 7
`define BIT_MFRAME_DIS 6
`define BIT_AUX_SEL 7
`define FLD_FORM8_LSB 2
`define FLD_FORM2_LSB 0
`define SYNTH_CLK_KHZ 77760
`define PHASE_BITS 24
`endif

// File: sync_clock_pkg.sv
// Types shared by the sync and digital clock block.
`default_nettype none
package sync_clock_pkg;
  // Form of a sync output: plain clock, plain pulse, inverted clock, inverted pulse.
  typedef enum logic [1:0] {
    FORM_CLOCK = 2'h0,
    FORM_PULSE = 2'h1,
    FORM_CLOCK_INV = 2'h2,
    FORM_PULSE_INV = 2'h3
  } sync_form_t;
  // Register write and read port bundle.
  typedef struct packed {
    logic wrEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  // Raw timing references from one timing path.
  typedef struct packed {
    logic tick8k;
    logic tick2k;
  } path_sync_t;
endpackage
`default_nettype wire

// File: sync_clock_out.sv
// Digital clock synthesis and frame/multiframe sync output generation.
`timescale 1ns/1ps
`default_nettype none
`include "sync_clock_params.svh"
module sync_clock_out #(
  parameter int PHASE_W = `PHASE_BITS
) (
  input wire logic clk,
  input wire logic reset,
  input wire sync_clock_pkg::reg_req_t regReq,
  output logic [7:0] regRdata,
  input wire logic synthClk77,
  input wire logic mainApllClk77,
  input wire logic useApllSource,
  input wire sync_clock_pkg::path_sync_t mainPath,
  input wire sync_clock_pkg::path_sync_t auxPath,
  input wire logic thirdPortClk,
  input wire logic [3:0] portFreqCode [4],
  output logic synthClockA,
  output logic synthClockB,
  output logic frameSyncOut,
  output logic multiframeSyncOut,
  output logic [3:0] portOut
);

  // Phase step for a DDS accumulating at 77.76 MHz; step = f * 2^W / 77760 kHz.
  function automatic logic [PHASE_W-1:0] phaseStep(input logic std, input logic [1:0] code);
    logic [31:0] baseKhz;
    logic [63:0] prod;
    baseKhz = std ? 32'h0000_0608 : 32'h0000_0800;
    prod = (64'(baseKhz) << code) << PHASE_W;
    phaseStep = PHASE_W'(prod / 64'(`SYNTH_CLK_KHZ));
  endfunction

  // Shapes one sync stream into clock, pulse or inverted forms.
  function automatic logic shapeSync(input logic [1:0] form, input logic level, input logic pulse);
    logic raw;
    raw = form[0] ? pulse : level;
    shapeSync = form[1] ? ~raw : raw;
  endfunction

  // Configuration registers; writes take effect on the next edge.
  logic [7:0] stdSel_r, stdSel_nxt;
  logic [7:0] freqSel_r, freqSel_nxt;
  logic [7:0] syncEn_r, syncEn_nxt;
  logic [7:0] syncForm_r, syncForm_nxt;

  // Register write decode; unmapped addresses are ignored.
  always_comb begin
    stdSel_nxt = stdSel_r;
    freqSel_nxt = freqSel_r;
    syncEn_nxt = syncEn_r;
    syncForm_nxt = syncForm_r;
    if (regReq.wrEn) begin
      unique case (regReq.addr)
        `REG_STD_SEL: stdSel_nxt = regReq.wdata;
        `REG_FREQ_SEL: freqSel_nxt = regReq.wdata;
        `REG_SYNC_EN: syncEn_nxt = regReq.wdata;
        `REG_SYNC_FORM: syncForm_nxt = regReq.wdata;
        default: begin
        end
      endcase
    end
  end

  // Register storage.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stdSel_r <= `RST_STD_SEL;
      freqSel_r <= `RST_FREQ_SEL;
      syncEn_r <= `RST_SYNC_EN;
      syncForm_r <= `RST_SYNC_FORM;
    end else begin
      stdSel_r <= stdSel_nxt;
      freqSel_r <= freqSel_nxt;
      syncEn_r <= syncEn_nxt;
      syncForm_r <= syncForm_nxt;
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    unique case (regReq.addr)
      `REG_STD_SEL: regRdata = stdSel_r;
      `REG_FREQ_SEL: regRdata = freqSel_r;
      `REG_SYNC_EN: regRdata = syncEn_r;
      `REG_SYNC_FORM: regRdata = syncForm_r;
      default: regRdata = 8'h00;
    endcase
  end

  // The synthesizer clock is chosen by a static strap, so a plain mux is adequate here.
  logic synthSrc;
  assign synthSrc = useApllSource ? mainApllClk77 : synthClk77;

  // Step words for the two synthesized clocks, worked out in the clk domain
  // from the registers. Each change flips a toggle that carries the news across.
  logic [PHASE_W-1:0] stepA_r, stepA_nxt; // Phase step of clock A.
  logic [PHASE_W-1:0] stepB_r, stepB_nxt; // Phase step of clock B.
  logic stepTgl_r, stepTgl_nxt; // Flips whenever either step word changes.

  // Step word next-state; the toggle flips in the same cycle as the words move.
  always_comb begin
    stepA_nxt = phaseStep(stdSel_r[`BIT_STD_A], freqSel_r[`FLD_FREQ_A_LSB +: 2]);
    stepB_nxt = phaseStep(stdSel_r[`BIT_STD_B], freqSel_r[`FLD_FREQ_B_LSB +: 2]);
    stepTgl_nxt = stepTgl_r;
    if ((stepA_nxt != stepA_r) || (stepB_nxt != stepB_r)) begin
      stepTgl_nxt = ~stepTgl_r;
    end
  end

  // Step word registers. They start at zero, so the first cycle after reset
  // already sees a change and hands the reset-value steps across.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stepA_r <= '0;
      stepB_r <= '0;
      stepTgl_r <= 1'b0;
    end else begin
      stepA_r <= stepA_nxt;
      stepB_r <= stepB_nxt;
      stepTgl_r <= stepTgl_nxt;
    end
  end

  // Synthesizer domain. The toggle passes two flip-flops before it is used and
  // a third stage remembers its last level; a difference loads the step words.
  // By then the words have stood still for at least two synthesizer cycles.
  // Limitation: a write that lands during a load may give one odd period, but
  // the load caused by that write follows and is always clean.
  logic [2:0] tglSync_r, tglSync_nxt; // Bit 0 first stage, bit 1 second, bit 2 memory.
  logic [PHASE_W-1:0] useA_r, useA_nxt; // Step in use by accumulator A.
  logic [PHASE_W-1:0] useB_r, useB_nxt; // Step in use by accumulator B.
  logic [PHASE_W-1:0] accA_r, accA_nxt; // Phase accumulator of clock A.
  logic [PHASE_W-1:0] accB_r, accB_nxt; // Phase accumulator of clock B.

  // Synthesizer next-state: load on a toggle edge, accumulate every cycle.
  always_comb begin
    tglSync_nxt = {tglSync_r[1:0], stepTgl_r};
    useA_nxt = useA_r;
    useB_nxt = useB_r;
    if (tglSync_r[2] != tglSync_r[1]) begin
      useA_nxt = stepA_r;
      useB_nxt = stepB_r;
    end
    accA_nxt = accA_r + useA_r;
    accB_nxt = accB_r + useB_r;
  end

  // Synthesizer registers on the chosen 77.76 MHz clock.
  always_ff @(posedge synthSrc or posedge reset) begin
    if (reset) begin
      tglSync_r <= 3'h0;
      useA_r <= '0;
      useB_r <= '0;
      accA_r <= '0;
      accB_r <= '0;
    end else begin
      tglSync_r <= tglSync_nxt;
      useA_r <= useA_nxt;
      useB_r <= useB_nxt;
      accA_r <= accA_nxt;
      accB_r <= accB_nxt;
    end
  end

  // Digital clock outputs straight from the accumulator MSB, bypassing any filter.
  // Edges land on the 77.76 MHz grid; that quantization is the jitter users see.
  assign synthClockA = accA_r[PHASE_W-1];
  assign synthClockB = accB_r[PHASE_W-1];

  // The synthesized clocks come back into the clk domain for the general ports
  // through two flip-flops each; only the second stage is read.
  logic [1:0] synA_r, synA_nxt; // Bit 0 first stage, bit 1 second stage.
  logic [1:0] synB_r, synB_nxt; // Bit 0 first stage, bit 1 second stage.

  // Synchroniser next-state.
  always_comb begin
    synA_nxt = {synA_r[0], synthClockA};
    synB_nxt = {synB_r[0], synthClockB};
  end

  // Synchroniser registers.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      synA_r <= 2'h0;
      synB_r <= 2'h0;
    end else begin
      synA_r <= synA_nxt;
      synB_r <= synB_nxt;
    end
  end

  // Sync level and pulse generation per timing path: level toggles each tick
  // for a 50:50 clock; a pulse is armed by a tick and held for one period of
  // the third port clock. Index 0 main, 1 aux.
  logic [1:0] lvl8_r, lvl8_nxt, lvl2_r, lvl2_nxt;
  logic [1:0] arm8_r, arm8_nxt, arm2_r, arm2_nxt;
  logic [1:0] pls8_r, pls8_nxt, pls2_r, pls2_nxt;
  logic thirdPrev_r, thirdRise;
  sync_clock_pkg::path_sync_t paths [2];
  assign paths[0] = mainPath;
  assign paths[1] = auxPath;
  assign thirdRise = thirdPortClk & ~thirdPrev_r;

  // Next-state of sync shapers.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      lvl8_nxt[i] = lvl8_r[i] ^ paths[i].tick8k;
      lvl2_nxt[i] = lvl2_r[i] ^ paths[i].tick2k;
      arm8_nxt[i] = arm8_r[i];
      arm2_nxt[i] = arm2_r[i];
      pls8_nxt[i] = pls8_r[i];
      pls2_nxt[i] = pls2_r[i];
      // A pulse opens at a rising third-port edge after a tick and closes at the next one.
      if (thirdRise) begin
        pls8_nxt[i] = arm8_r[i];
        pls2_nxt[i] = arm2_r[i];
        arm8_nxt[i] = 1'b0;
        arm2_nxt[i] = 1'b0;
      end
      // Only the tick that raises the clock level arms a pulse, so pulses keep
      // the clock's rate; set wins over the disarm above.
      if (paths[i].tick8k && !lvl8_r[i]) begin
        arm8_nxt[i] = 1'b1;
      end
      if (paths[i].tick2k && !lvl2_r[i]) begin
        arm2_nxt[i] = 1'b1;
      end
    end
  end

  // Sync shaper registers.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lvl8_r <= 2'h0;
      lvl2_r <= 2'h0;
      arm8_r <= 2'h0;
      arm2_r <= 2'h0;
      pls8_r <= 2'h0;
      pls2_r <= 2'h0;
      thirdPrev_r <= 1'b0;
    end else begin
      lvl8_r <= lvl8_nxt;
      lvl2_r <= lvl2_nxt;
      arm8_r <= arm8_nxt;
      arm2_r <= arm2_nxt;
      pls8_r <= pls8_nxt;
      pls2_r <= pls2_nxt;
      thirdPrev_r <= thirdPortClk;
    end
  end

  // Shaped sync streams, computed for both paths.
  logic [1:0] form8, form2;
  logic [1:0] shaped8, shaped2;
  assign form8 = syncForm_r[`FLD_FORM8_LSB +: 2];
  assign form2 = syncForm_r[`FLD_FORM2_LSB +: 2];
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      shaped8[i] = shapeSync(form8, lvl8_r[i], pls8_r[i]);
      shaped2[i] = shapeSync(form2, lvl2_r[i], pls2_r[i]);
    end
  end

  // Path chosen for the general ports.
  logic portPath;
  assign portPath = syncForm_r[`BIT_AUX_SEL];

  // Registered sync and port outputs.
  logic frame_r, frame_nxt, mframe_r, mframe_nxt;
  logic [3:0] port_r, port_nxt;

  // Output selection.
  always_comb begin
    // Dedicated syncs use the main path only; disabled ones sit low.
    frame_nxt = syncEn_r[`BIT_FRAME_DIS] ? 1'b0 : shaped8[0];
    mframe_nxt = syncEn_r[`BIT_MFRAME_DIS] ? 1'b0 : shaped2[0];
    for (int p = 0; p < 4; p++) begin
      unique case (portFreqCode[p])
        4'h0: port_nxt[p] = 1'b0;
        4'h1: port_nxt[p] = shaped2[portPath];
        4'h2: port_nxt[p] = shaped8[portPath];
        4'h3: port_nxt[p] = (p == 0) ? 1'b0 : synB_r[1];
        4'h4: port_nxt[p] = synA_r[1];
        default: port_nxt[p] = 1'b0;
      endcase
    end
  end

  // Output registers.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame_r <= 1'b0;
      mframe_r <= 1'b0;
      port_r <= 4'h0;
    end else begin
      frame_r <= frame_nxt;
      mframe_r <= mframe_nxt;
      port_r <= port_nxt;
    end
  end

  assign frameSyncOut = frame_r;
  assign multiframeSyncOut = mframe_r;
  assign portOut = port_r;

endmodule
`default_nettype wire

// File: sync_clock_monitor.sv
// Concurrent checks on the sync and digital clock block ports.
`timescale 1ns/1ps
`default_nettype none
module sync_clock_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire sync_clock_pkg::reg_req_t regReq,
  input wire logic [7:0] regRdata,
  input wire logic [3:0] portFreqCode [4],
  input wire logic frameSyncOut,
  input wire logic multiframeSyncOut,
  input wire logic [3:0] portOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic [7:0] a = regReq.addr; // Address under access.
  // Two quiet cycles reading a set disable bit, so the output register has seen it.
  sequence off_s(int b); (a == 8'h63 && regRdata[b] && !regReq.wrEn) [*2]; endsequence
  unmapped_read_a: assert property (!(a inside {8'h38, 8'h39, 8'h63, 8'h7A}) |-> regRdata == 8'h00)
    else $error("unmapped read not zero");
  freq_writeback_a: assert property (regReq.wrEn && a == 8'h39 ##1 a == 8'h39 |-> regRdata == $past(regReq.wdata))
    else $error("frequency write lost");
  std_hold_a: assert property ((a == 8'h38 && !regReq.wrEn) [*2] |-> $stable(regRdata))
    else $error("standard register drifted");
  frame_off_a: assert property (off_s(7) |-> !frameSyncOut)
    else $error("frame sync not held");
  mframe_off_a: assert property (off_s(6) |-> !multiframeSyncOut)
    else $error("multiframe sync not held");
  port_off_a: assert property ((portFreqCode[0] == 4'h0) [*2] |-> !portOut[0])
    else $error("port off toggles");
  port0_nosynthb_a: assert property ((portFreqCode[0] == 4'h3) [*2] |-> !portOut[0])
    else $error("port zero code three active");
  port_unused_a: assert property ((portFreqCode[2] > 4'h4) [*2] |-> !portOut[2])
    else $error("unused code active");
endmodule
`default_nettype wire

// File: sync_source_model.sv
// Timing path ticks and third port clock that feed the sync block.
`timescale 1ns/1ps
`default_nettype none
module sync_source_model #(
  parameter int MAIN_DIV = 16,
  parameter int AUX_DIV = 24
) (
  input wire logic clk,
  input wire logic reset,
  output var sync_clock_pkg::path_sync_t mainPath,
  output var sync_clock_pkg::path_sync_t auxPath,
  output logic thirdPortClk
);
  int cnt_r; // Free count; unequal path rates let the bench tell the paths apart.
  always @(posedge clk or posedge reset) cnt_r <= reset ? 0 : cnt_r + 1;
  // One-cycle ticks, 2 kHz at a quarter of the 8 kHz rate.
  always_comb begin
    mainPath.tick8k = (cnt_r % MAIN_DIV) == 0;
    mainPath.tick2k = (cnt_r % (4 * MAIN_DIV)) == 0;
    auxPath.tick8k = (cnt_r % AUX_DIV) == 0;
    auxPath.tick2k = (cnt_r % (4 * AUX_DIV)) == 0;
    thirdPortClk = cnt_r[1];
  end
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the sync and digital clock block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, reset = 1, s77 = 0, a77 = 0, s77On = 1, useApll = 0, tpc, clkA, clkB, fs, mfs;
  sync_clock_pkg::reg_req_t req = '0;
  sync_clock_pkg::path_sync_t mainPath, auxPath;
  logic [7:0] rdata;
  logic [3:0] pout;
  logic [3:0] code [4] = '{default: 4'h0};
  logic [7:0] regs [4] = '{8'h38, 8'h39, 8'h63, 8'h7A};
  int khz [8] = '{2048, 4096, 8192, 16384, 1544, 3088, 6176, 12352};
  int miscompares = 0, n_checks = 0, cyc = 0, nA, nB, hi [4], ri [4];
  always #4 clk = ~clk;
  always #6.43 s77 = s77On & ~s77;
  initial #3 forever #6.43 a77 = ~a77;
  always @(posedge clkA) nA++;
  always @(posedge clkB) nB++;
  sync_clock_out uut (.clk(clk), .reset(reset), .regReq(req), .regRdata(rdata), .synthClk77(s77),
    .mainApllClk77(a77), .useApllSource(useApll), .mainPath(mainPath), .auxPath(auxPath),
    .thirdPortClk(tpc), .portFreqCode(code), .synthClockA(clkA), .synthClockB(clkB),
    .frameSyncOut(fs), .multiframeSyncOut(mfs), .portOut(pout));
  sync_source_model src (.clk(clk), .reset(reset), .mainPath(mainPath), .auxPath(auxPath),
    .thirdPortClk(tpc));
  task automatic near(string n, int e, int g, int t);
    n_checks++;
    if (g < e - t || g > e + t) begin
      miscompares++;
      $display("unexpected %s exp %0d got %0d", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    @(negedge clk);
    req = '{wrEn: 1'b1, addr: ad, wdata: d};
    @(negedge clk);
    req.wrEn = 1'b0;
  endtask
  task automatic rd(logic [7:0] ad, logic [7:0] e);
    req.addr = ad;
    @(negedge clk);
    n_checks++;
    if (rdata !== e) begin
      miscompares++;
      $display("unexpected regRdata exp %h got %h", e, rdata);
    end
  endtask
  // Counts high cycles and rising edges of the syncs and ports 1 and 3 over 1024 cycles.
  task automatic meas(logic inv);
    logic [3:0] s, p;
    hi = '{0, 0, 0, 0};
    ri = '{0, 0, 0, 0};
    p = 4'hF;
    repeat (1024) begin
      @(negedge clk);
      s = {pout[3], pout[1], mfs ^ inv, fs ^ inv};
      for (int i = 0; i < 4; i++) begin
        hi[i] += (s[i] !== 1'b0);
        ri[i] += s[i] & !p[i];
      end
      p = s;
    end
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hang guard sized above the roughly 65500 cycles of the sequence.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 90000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    reset = 0;
    rd(8'h40, 8'h00);
    foreach (regs[i]) rd(regs[i], 8'h00);
    foreach (regs[i]) wr(regs[i], {regs[i][3:0], regs[i][7:4]});
    foreach (regs[i]) rd(regs[i], {regs[i][3:0], regs[i][7:4]});
    // Clock B takes the mirrored code so a swap of the two fields shows.
    for (int i = 0; i < 8; i++) begin
      wr(8'h38, {1'b0, ~i[2], i[2], 5'h00});
      wr(8'h39, {~i[1:0], i[1:0], 4'h0});
      nA = 0;
      nB = 0;
      #50000;
      near("synthClockA", khz[i] / 20, nA, 3);
      near("synthClockB", khz[7 - i] / 20, nB, 3);
    end
    s77On = 0;
    useApll = 1;
    nA = 0;
    #50000;
    near("synthClockA", khz[7] / 20, nA, 3);
    code = '{4'h3, 4'h2, 4'h5, 4'h1};
    wr(8'h63, 8'h00);
    for (int b = 0; b < 2; b++) begin
      wr(8'h7A, {b[0], 7'h00});
      meas(1'b0);
      near("portOut1", b ? 21 : 32, ri[2], 1);
      near("portOut3", b ? 5 : 8, ri[3], 1);
      near("frameSyncOut", 32, ri[0], 1);
    end
    code[1] = 4'h4;
    code[3] = 4'h3;
    meas(1'b0);
    near("portOut1", khz[7] * 8192 / 1000000, ri[2], 2);
    near("portOut3", khz[0] * 8192 / 1000000, ri[3], 2);
    for (int f = 0; f < 4; f++) begin
      wr(8'h7A, {4'h0, f[1:0], f[1:0]});
      meas(f[1]);
      for (int k = 0; k < 2; k++) begin
        near("syncEdges", k ? 8 : 32, ri[k], 1);
        near("syncHigh", f[0] ? 4 * ri[k] : 512, hi[k], f[0] ? 8 : 64);
      end
    end
    wr(8'h7A, 8'h00);
    for (int j = 0; j < 2; j++) begin
      wr(8'h63, j ? 8'h40 : 8'h80);
      rd(8'h63, j ? 8'h40 : 8'h80);
      meas(1'b0);
      near("disabledSyncHigh", 0, hi[j], 0);
      near("enabledSyncEdges", j ? 32 : 8, ri[1 - j], 1);
    end
    give_verdict();
  end
endmodule
bind sync_clock_out sync_clock_monitor mon (.clk(clk), .reset(reset), .regReq(regReq), .regRdata(regRdata),
  .portFreqCode(portFreqCode), .frameSyncOut(frameSyncOut), .multiframeSyncOut(multiframeSyncOut),
  .portOut(portOut));
`default_nettype wire
